/* File: rtl/slfc_pkg.sv */
/*
 Package for the store-to-load forwarding check: size codes, buffer
 geometry defaults and sequencer state encodings.
 Assumes sizes are carried as log2 of the byte count.
*/
package slfc_pkg;
   localparam int unsigned SIZE_W      = 3;
   localparam logic [2:0]  SZ_8        = 3'h0;
   localparam logic [2:0]  SZ_16       = 3'h1;
   localparam logic [2:0]  SZ_32       = 3'h2;
   localparam logic [2:0]  SZ_64       = 3'h3;
   localparam logic [2:0]  SZ_128      = 3'h4;
   localparam int unsigned ADDR_W_DEF  = 32;
   localparam int unsigned DATA_W_DEF  = 128;
   localparam int unsigned ENTRIES_DEF = 8;
   localparam logic [3:0]  UNALIGN_1   = 4'h1;
   localparam logic [3:0]  UNALIGN_7   = 4'h7;

   typedef enum logic [2:0] {
      SLFC_IDLE  = 3'b001,
      SLFC_WAIT  = 3'b010,
      SLFC_READ  = 3'b100
   } slfc_state_t;
endpackage : slfc_pkg

/* File: rtl/slfc_check.sv */
/*
 Store-to-load forwarding check for the load/store unit.
 Assumes the store buffer presents every entry in parallel, oldest at
 index 0, and that an entry leaves only after it has written the cache.
*/
`timescale 1ns/10ps

// Behaviour
// - Aligned 16/32-bit store: forward loads at offset 0 and a 16-bit load at offset 2 of a 32-bit store; others stall.
// - Aligned 64/128-bit store forwards 32-bit and wider loads on their own size boundary, 8/16-bit loads at offset 0 only; others stall.
// - Start-byte-1 32/64-bit store forwards 8/16/32 loads at its first byte only.
// - Start-byte-7 32-bit store forwards byte loads; wider loads stall.
// - Wide load spanning several narrower stores is blocked and stalls.
// - Blocked load waits for stores to drain, then reads the cache.
// - 16-bit loads at offset 2 or 4 in a 64-bit store stall.
// - Wide-after-narrow stall applies to every width pairing.
// - Byte store forwards same-address byte load past older wider store.
// - Forward only with load inside store and same start address, unless the store is naturally aligned or starts at byte 7.
// - Independent loads proceed; only dependent loads wait.
// - Store data reaches the cache only after the store retires.
module slfc_check #(
   parameter int unsigned ADDR_W  = slfc_pkg::ADDR_W_DEF,
   parameter int unsigned DATA_W  = slfc_pkg::DATA_W_DEF,
   parameter int unsigned ENTRIES = slfc_pkg::ENTRIES_DEF
) (
   input  wire logic                ref_clk_in,      // Core clock
   input  wire logic                rst_n_in,        // Sync reset, low
   input  wire logic                clk_en_in,       // Freezes state
   input  wire logic                ld_valid_in,     // Load request
   output logic                     ld_ready_out,    // Load accepted
   input  wire logic [ADDR_W-1:0]   ld_addr_in,      // Load address
   input  wire logic [2:0]          ld_size_in,      // Load log2 bytes
   input  wire logic [ENTRIES-1:0]  sb_valid_in,     // Entry holds store
   input  wire logic [ENTRIES-1:0]  sb_older_in,     // Entry older than load
   input  wire logic [ENTRIES*ADDR_W-1:0] sb_addr_in, // Store addresses
   input  wire logic [ENTRIES*3-1:0] sb_size_in,     // Store log2 bytes
   input  wire logic [ENTRIES*DATA_W-1:0] sb_data_in, // Store data
   input  wire logic [ENTRIES-1:0]  sb_retired_in,   // Store retired
   output logic [ENTRIES-1:0]       sb_drain_ok_out, // May write cache
   output logic                     mem_req_out,     // Cache read request
   output logic [ADDR_W-1:0]        mem_addr_out,    // Cache read address
   output logic [2:0]               mem_size_out,    // Cache read size
   input  wire logic                mem_ack_in,      // Cache data valid
   input  wire logic [DATA_W-1:0]   mem_data_in,     // Cache read data
   output logic                     res_valid_out,   // Load result valid
   output logic [DATA_W-1:0]        res_data_out,    // Load result data
   output logic                     res_fwd_out,     // Result forwarded
   output logic                     stall_out        // Load is stalled
);
   initial begin
      if (ENTRIES < 1 || ENTRIES > 32 || DATA_W != 128 || ADDR_W < 8)
         $error("slfc_check: unsupported parameters");
   end

   localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

   // Overlap detection and youngest-older selection
   logic [ENTRIES-1:0] ovl;
   genvar g;
   for (g = 0; g < ENTRIES; g++) begin : g_ovl
      logic [ADDR_W-1:0] sa;
      logic [ADDR_W-1:0] send;
      logic [ADDR_W-1:0] lend;
      assign sa   = sb_addr_in[g*ADDR_W +: ADDR_W];
      assign send = sa + (ADDR_W'(1) << sb_size_in[g*3 +: 3]);
      assign lend = ld_addr_in + (ADDR_W'(1) << ld_size_in);
      assign ovl[g] = sb_valid_in[g] && sb_older_in[g]
                      && (sa < lend) && (ld_addr_in < send);
   end

   logic          hit;
   logic [IW-1:0] sel;
   always_comb begin
      hit = 1'b0;
      sel = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (ovl[i]) begin
            hit = 1'b1;
            sel = IW'(i);
         end
      end
   end

   logic [ADDR_W-1:0] s_addr;
   logic [2:0]        s_size;
   logic [DATA_W-1:0] s_data;
   logic [3:0]        s_off;
   logic [3:0]        l_off;
   logic              s_nat;
   logic              allow;
   assign s_addr = sb_addr_in[sel*ADDR_W +: ADDR_W];
   assign s_size = sb_size_in[sel*3 +: 3];
   assign s_data = sb_data_in[sel*DATA_W +: DATA_W];
   assign s_off  = s_addr[3:0];
   assign l_off  = 4'(ld_addr_in - s_addr);
   assign s_nat  = ((s_addr[3:0] & ((4'h1 << s_size) - 4'h1)) == 4'h0);

   // Width and alignment decision for the selected store
   always_comb begin
      allow = 1'b0;
      if (ld_addr_in < s_addr || ld_size_in > s_size) begin
         allow = 1'b0;
      end else if (s_nat) begin
         // Byte and word loads only at offset 0, except a word in a
         // 32-bit store; wider loads on their own size boundary
         allow = ((l_off & ((4'h1 << ld_size_in) - 4'h1)) == 4'h0)
                 && (ld_size_in >= slfc_pkg::SZ_32 || l_off == 4'h0
                     || (s_size == slfc_pkg::SZ_32
                         && ld_size_in == slfc_pkg::SZ_16));
      end else if (s_off[2:0] == 3'(slfc_pkg::UNALIGN_1)) begin
         allow = (l_off == 4'h0) && ld_size_in <= slfc_pkg::SZ_32
                 && (s_size == slfc_pkg::SZ_32
                     || s_size == slfc_pkg::SZ_64);
      end else if (s_off[2:0] == 3'(slfc_pkg::UNALIGN_7)) begin
         allow = (ld_size_in == slfc_pkg::SZ_8)
                 && (s_size == slfc_pkg::SZ_32);
      end
      allow = allow && (ld_addr_in == s_addr || s_nat
                        || s_off[2:0] == 3'(slfc_pkg::UNALIGN_7));
   end

   logic [DATA_W-1:0] fwd_data;
   assign fwd_data = DATA_W'(s_data >> {l_off, 3'h0});

   // Load sequencer
   slfc_pkg::slfc_state_t st_q, st_d;
   logic [ENTRIES-1:0] blk_q, blk_d;
   logic [ADDR_W-1:0]  la_q, la_d;
   logic [2:0]         ls_q, ls_d;
   logic               rv_q, rv_d;
   logic               rf_q, rf_d;
   logic [DATA_W-1:0]  rd_q, rd_d;

   always_comb begin
      st_d = st_q;
      blk_d = blk_q & sb_valid_in;
      la_d = la_q;
      ls_d = ls_q;
      rv_d = 1'b0;
      rf_d = rf_q;
      rd_d = rd_q;
      unique case (st_q)
         slfc_pkg::SLFC_IDLE: begin
            if (ld_valid_in) begin
               la_d = ld_addr_in;
               ls_d = ld_size_in;
               if (!hit) begin
                  st_d = slfc_pkg::SLFC_READ;
               end else if (allow) begin
                  rv_d = 1'b1;
                  rf_d = 1'b1;
                  rd_d = fwd_data;
               end else begin
                  blk_d = ovl;
                  st_d = slfc_pkg::SLFC_WAIT;
               end
            end
         end
         slfc_pkg::SLFC_WAIT: begin
            if ((blk_q & sb_valid_in) == '0)
               st_d = slfc_pkg::SLFC_READ;
         end
         slfc_pkg::SLFC_READ: begin
            if (mem_ack_in) begin
               rv_d = 1'b1;
               rf_d = 1'b0;
               rd_d = mem_data_in;
               st_d = slfc_pkg::SLFC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_q  <= slfc_pkg::SLFC_IDLE;
         blk_q <= '0;
         la_q  <= '0;
         ls_q  <= slfc_pkg::SZ_8;
         rv_q  <= 1'b0;
         rf_q  <= 1'b0;
         rd_q  <= '0;
      end else if (clk_en_in) begin
         st_q  <= st_d;
         blk_q <= blk_d;
         la_q  <= la_d;
         ls_q  <= ls_d;
         rv_q  <= rv_d;
         rf_q  <= rf_d;
         rd_q  <= rd_d;
      end
   end

   assign ld_ready_out    = (st_q == slfc_pkg::SLFC_IDLE) && clk_en_in;
   assign sb_drain_ok_out = sb_valid_in & sb_retired_in;
   assign mem_req_out     = (st_q == slfc_pkg::SLFC_READ);
   assign mem_addr_out    = la_q;
   assign mem_size_out    = ls_q;
   assign res_valid_out   = rv_q;
   assign res_fwd_out     = rf_q;
   assign res_data_out    = rd_q;
   assign stall_out       = (st_q == slfc_pkg::SLFC_WAIT);

   a_drain_retired: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      sb_drain_ok_out != '0 |-> (sb_drain_ok_out & ~sb_retired_in) == '0)
      else $error("drain before retire");
   a_wait_to_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      stall_out && clk_en_in && (blk_q & sb_valid_in) == '0 |=> mem_req_out)
      else $error("wait did not end in read");
   a_blocked_stall: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ld_ready_out && ld_valid_in && hit && !allow |=> stall_out)
      else $error("blocked load not stalled");
   a_fwd_result: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ld_ready_out && ld_valid_in && hit && allow
      |=> res_valid_out && res_fwd_out)
      else $error("forward result missing");
   a_free_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ld_ready_out && ld_valid_in && !hit |=> mem_req_out && !stall_out)
      else $error("independent load stalled");
   a_wide_block: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      hit && ld_size_in > s_size |-> !allow)
      else $error("wide load forwarded");
   a_pair_16_64: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      hit && s_nat && s_size == slfc_pkg::SZ_64 && ld_size_in == slfc_pkg::SZ_16
      && (l_off == 4'h2 || l_off == 4'h4) |-> !allow)
      else $error("16-bit load at 2 or 4 forwarded");
   a_byte7_wide: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      hit && !s_nat && s_off[2:0] == 3'h7 && ld_size_in != slfc_pkg::SZ_8
      |-> !allow)
      else $error("wide load from byte-7 store forwarded");
endmodule : slfc_check

/* File: sim/slfc_far_model.sv */
/* Far side model: cache reads and store buffer drain.
   Assumes read requests are held until acknowledged. */
`timescale 1ns/10ps
module slfc_far_model (
   input  wire logic         ref_clk_in,  // Core clock
   input  wire logic         rst_n_in,    // Sync reset, low
   input  wire logic         slow_in,     // Stretch read latency
   input  wire logic         req_in,      // Cache read request
   input  wire logic [31:0]  addr_in,     // Cache read address
   input  wire logic [7:0]   drain_ok_in, // Entries allowed out
   output logic              ack_out,     // Read data valid
   output logic [127:0]      data_out,    // Read data
   output logic [7:0]        drained_out  // Entries written
);
   logic [2:0] wait_q;
   always @(posedge ref_clk_in) begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      drained_out <= drain_ok_in;
      if (!rst_n_in)
         data_out <= '0;
      if (!(rst_n_in && req_in) || ack_out)
         wait_q <= 3'h0;
      else if (wait_q >= {slow_in, 2'h0}) begin
         ack_out <= 1'b1;
         for (int i = 0; i < 16; i++)
            data_out[8*i +: 8] <= addr_in[7:0] + 8'(i) + 8'h30;
      end
      else
         wait_q <= wait_q + 3'h1;
   end
endmodule : slfc_far_model

/* File: sim/tb_store_load_forward_check.sv */
/* Bench for the store-to-load forwarding check.
   Assumes the far model answers reads and drains retired entries. */
`timescale 1ns/10ps
module tb_store_load_forward_check;
   localparam logic [31:0] B = 32'h0000_1000;
   localparam logic [2:0] S8 = slfc_pkg::SZ_8;
   localparam logic [2:0] S16 = slfc_pkg::SZ_16;
   localparam logic [2:0] S32 = slfc_pkg::SZ_32;
   localparam logic [2:0] S64 = slfc_pkg::SZ_64;
   localparam logic [2:0] S128 = slfc_pkg::SZ_128;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, ld_valid_in = 1'b0, slow = 1'b0;
   logic ld_ready_out, mem_req_out, mem_ack_in, res_valid_out;
   logic res_fwd_out, stall_out;
   logic [31:0] ld_addr_in = '0, mem_addr_out;
   logic [2:0] ld_size_in = '0, mem_size_out;
   logic [7:0] sb_valid_in = '0, sb_retired_in = '0, sb_drain_ok_out, drained;
   logic [255:0] sb_addr_in = '0;
   logic [23:0] sb_size_in = '0;
   logic [1023:0] sb_data_in = '0;
   logic [127:0] mem_data_in, res_data_out;
   int n_mismatch = 0, n_compared = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in)
      if (|drained)
         sb_valid_in <= sb_valid_in & ~drained;
   slfc_check i_dut (.ref_clk_in, .rst_n_in, .clk_en_in(1'b1), .ld_valid_in,
      .ld_ready_out, .ld_addr_in, .ld_size_in, .sb_valid_in,
      .sb_older_in(8'hFF), .sb_addr_in, .sb_size_in, .sb_data_in,
      .sb_retired_in, .sb_drain_ok_out, .mem_req_out, .mem_addr_out,
      .mem_size_out, .mem_ack_in, .mem_data_in, .res_valid_out,
      .res_data_out, .res_fwd_out, .stall_out);
   slfc_far_model i_far (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .slow_in(slow), .req_in(mem_req_out), .addr_in(mem_addr_out),
      .drain_ok_in(sb_drain_ok_out), .ack_out(mem_ack_in),
      .data_out(mem_data_in), .drained_out(drained));
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_data(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t data %h want %h", $time, got, exp);
      end
   endtask : chk_data
   function automatic logic [127:0] pat(input logic [31:0] a);
      for (int i = 0; i < 16; i++)
         pat[8*i +: 8] = a[7:0] + 8'(i) + 8'h30;
   endfunction : pat
   task automatic put_store(input int e, input logic [31:0] a,
                            input logic [2:0] sz, input logic [7:0] salt);
      sb_valid_in[e] <= 1'b1;
      sb_addr_in[32*e +: 32] <= a;
      sb_size_in[3*e +: 3] <= sz;
      sb_data_in[128*e +: 128] <= pat(a) ^ {16{salt}};
   endtask : put_store
   // e: 0 read from cache, 1 forwarded, 2 stalled
   task automatic do_load(input logic [31:0] a, input logic [2:0] sz,
                          input int e);
      logic early;
      logic [127:0] m;
      early = 1'b0;
      m = ~128'h0 >> (128 - (8 << sz));
      for (int n = 0; n < 20 && ld_ready_out !== 1'b1; n++)
         @(negedge ref_clk_in);
      @(posedge ref_clk_in);
      ld_valid_in <= 1'b1;
      ld_addr_in <= a;
      ld_size_in <= sz;
      @(posedge ref_clk_in);
      ld_valid_in <= 1'b0;
      @(negedge ref_clk_in);
      chk_bit(stall_out, e == 2);
      chk_bit(res_valid_out, e == 1);
      chk_bit(mem_req_out, e == 0);
      if (e == 2) begin
         chk_bit(|sb_drain_ok_out, 1'b0);
         @(posedge ref_clk_in);
         sb_retired_in <= sb_valid_in;
      end
      for (int n = 0; n < 40 && res_valid_out !== 1'b1; n++) begin
         @(negedge ref_clk_in);
         early |= e == 2 && mem_req_out === 1'b1 && sb_valid_in != 0;
      end
      chk_bit(early, 1'b0);
      chk_bit(res_fwd_out, e == 1);
      chk_data(res_data_out & m, pat(a) & m);
      @(posedge ref_clk_in);
      sb_valid_in <= '0;
      sb_retired_in <= '0;
   endtask : do_load
   task automatic one_case(input int so, input logic [2:0] ss, input int lo,
                           input logic [2:0] ls, input int e);
      @(posedge ref_clk_in);
      put_store(0, B + so, ss, 8'h00);
      do_load(B + lo, ls, e);
   endtask : one_case
   task automatic print_verdict();
      $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      one_case(0, S16, 0, S8, 1);
      one_case(0, S16, 1, S8, 2);
      one_case(0, S32, 0, S32, 1);
      one_case(0, S32, 1, S16, 2);
      one_case(0, S32, 2, S16, 1);
      one_case(0, S32, 2, S8, 2);
      one_case(0, S64, 6, S16, 2);
      one_case(0, S64, 3, S8, 2);
      one_case(0, S64, 4, S32, 1);
      one_case(0, S128, 8, S64, 1);
      one_case(0, S64, 2, S16, 2);
      one_case(0, S64, 4, S16, 2);
      one_case(0, S64, 0, S64, 1);
      one_case(0, S128, 4, S64, 2);
      one_case(0, S128, 0, S128, 1);
      one_case(1, S32, 1, S32, 1);
      one_case(1, S32, 2, S16, 2);
      one_case(1, S64, 1, S64, 2);
      one_case(7, S32, 8, S8, 1);
      one_case(7, S64, 7, S16, 2);
      slow <= 1'b1;
      @(posedge ref_clk_in);
      for (int i = 0; i < 4; i++)
         put_store(i, B + i, S8, 8'h00);
      do_load(B, S32, 2);
      @(posedge ref_clk_in);
      put_store(0, B, S16, 8'h00);
      put_store(1, B + 2, S16, 8'h00);
      do_load(B, S32, 2);
      @(posedge ref_clk_in);
      put_store(0, B, S32, 8'hFF);
      put_store(1, B, S8, 8'h00);
      do_load(B, S8, 1);
      @(posedge ref_clk_in);
      put_store(0, B, S32, 8'h00);
      do_load(B + 32'h100, S32, 0);
      print_verdict();
   end
   initial begin
      #100us;
      n_mismatch++;
      print_verdict();
   end
endmodule : tb_store_load_forward_check
